// file: core/byte_buf_if.sv
// Purpose: carries fill and drain handshakes of the holding buffer
// Assumes: one byte per entry
// Notes:   mover drives push side and pop_ready
`timescale 1ns/100ps
interface byte_buf_if;
	logic       push_valid;
	logic       push_ready;
	logic [7:0] push_data;
	logic       pop_valid;
	logic       pop_ready;
	logic [7:0] pop_data;
	modport mover (output push_valid, push_data, pop_ready,
		input push_ready, pop_valid, pop_data);
	modport store (input push_valid, push_data, pop_ready,
		output push_ready, pop_valid, pop_data);
endinterface

// file: core/byte_dma.sv
// Purpose: two-channel byte mover with shared register window
// Assumes: memory read data valid in the cycle o_mem_re is high
// Notes:   o_cpu_stall freezes the cpu while a byte is moved
`timescale 1ns/100ps
// How it works
// [R1] channel zero wins when both pending
// [R2] read to holding buffer, write next cycle
// [R3] one idle cpu cycle between transfers
// [R4] no transfers in wait, stop, hold
// [R5] single mode one byte; burst repeats
// [R6] mode bits step each address independently
// [R7] count decrements, underflow reloads, flags, interrupts
// [R8] underflow reloads addresses unless globally disabled
// [R9] stop option clears enable at underflow
// [R10] reload bit copies latches to working registers
// [R11] low then high write fills latches
// [R12] immediate load unless deferred write set
// [R13] high read freezes low byte
// [R14] index bit seven picks channel window
// [R15] zero source code means software only
// [R16] channel zero source vector selected
// [R17] channel one source vector selected
// [R18] software bit raises a request
// [R19] request latch sampled on clock edge
// [R20] clear bit or acceptance empties latch
// [R21] repeated requests merge into one
// [R22] endpoint assist only with enable bit
// [R23] burst length follows the count
// [R24] addresses wrap, count at zero reloads from its latch
module byte_dma (
	// clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	// register window
	input  wire logic [7:0]  i_sfr_addr,
	input  wire logic [7:0]  i_sfr_wdata,
	input  wire logic        i_sfr_we,
	input  wire logic        i_sfr_re,
	output logic      [7:0]  o_sfr_rdata,
	// memory bus
	output logic      [15:0] o_mem_addr,
	output logic             o_mem_re,
	output logic             o_mem_we,
	output logic      [7:0]  o_mem_wdata,
	input  wire logic [7:0]  i_mem_rdata,
	input  wire logic        i_mem_wait,
	// cpu and device state
	output logic             o_cpu_stall,
	input  wire logic        i_wait_state,
	input  wire logic        i_stop_state,
	input  wire logic        i_bus_hold,
	// request sources
	input  wire logic [15:0] i_hw_req_ch0,
	input  wire logic [15:0] i_hw_req_ch1,
	input  wire logic [1:0]  i_outbuf_empty,
	input  wire logic [1:0]  i_inbuf_data,
	output logic      [1:0]  o_chan_irq
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	logic [7:0]  mode1 [2];
	logic [7:0]  mode2 [2];
	// work and latch rows: 0 source, 1 destination, 2 count
	logic [15:0] work  [2][3];
	logic [15:0] latch [2][3];
	logic [7:0]  wlo   [2][3];
	logic [7:0]  rdlo  [2][3];
	logic [1:0]  uf;
	logic        idx;
	logic        rld_dis;
	logic [1:0]  pend;
	logic [1:0]  prev;
	logic        ch;
	dma_pkg::mover_state_t state;
	dma_pkg::mover_state_t next_state;
	logic        next_re;
	logic        next_we;
	logic [15:0] next_addr;
	logic        next_ch;
	byte_buf_if  buf_bus ();

	hold_buffer u_buf (
		.i_clk (i_clk),
		.i_rst (i_rst),
		.bus   (buf_bus.store)
	);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [15:0] step(input logic [15:0] a, input logic en,
		input logic dn);
		return !en ? a : (dn ? 16'(a - 16'h0001) : 16'(a + 16'h0001)); // [R24]
	endfunction

	// channel number to a pair of per-channel strobes
	function automatic logic [1:0] one_hot(input logic c);
		return {c, !c};
	endfunction

	function automatic logic req_cond(input logic [3:0] sel, input logic [15:0] hw,
		input logic assist, input logic ob_empty, input logic ib_data);
		logic rx;
		logic tx;
		rx = (sel >= dma_pkg::EP_RX_FIRST && sel <= dma_pkg::EP_RX_LAST)
			|| sel == dma_pkg::EP_NOT_EMPTY;
		tx = sel >= dma_pkg::EP_TX_FIRST && sel <= dma_pkg::EP_TX_LAST;
		if (sel == dma_pkg::HW_REQUEST_NONE) return 1'b0; // [R15]
		if (assist && rx) return hw[sel] && ob_empty; // [R22]
		if (assist && tx) return !hw[sel] && ib_data; // [R22]
		return hw[sel];
	endfunction

	// ----------------------------------------
	// register decode
	// ----------------------------------------
	wire       wr_idx = i_sfr_we && i_sfr_addr == dma_pkg::A_INDEX_STATUS;
	wire       wr_m1  = i_sfr_we && i_sfr_addr == dma_pkg::A_MODE_FIRST;
	wire       wr_m2  = i_sfr_we && i_sfr_addr == dma_pkg::A_MODE_SECOND;
	wire       in_win = i_sfr_addr >= dma_pkg::A_SOURCE_LOW
		&& i_sfr_addr <= dma_pkg::A_COUNT_HIGH;
	wire [7:0] woff   = 8'(i_sfr_addr - dma_pkg::A_SOURCE_LOW);
	// kk picks source, destination or count inside the shared window
	wire [1:0] kk     = in_win ? woff[2:1] : 2'd0;
	wire       hi     = woff[0];
	wire       wr_hi  = i_sfr_we && in_win && hi;
	wire       wr_lo  = i_sfr_we && in_win && !hi;
	wire       rd_hi  = i_sfr_re && in_win && hi;
	wire [15:0] whole = {i_sfr_wdata, wlo[idx][kk]}; // [R11]
	wire       m2_bit_swt = i_sfr_wdata[dma_pkg::SOFTWARE_REQUEST_BIT];
	wire       m2_bit_crr = i_sfr_wdata[dma_pkg::REQUEST_LATCH_CLEAR];
	wire       m2_bit_rld = i_sfr_wdata[dma_pkg::FORCE_RELOAD_BIT];
	wire [1:0] ch_sel = one_hot(idx); // [R14]
	wire [1:0] swt    = (wr_m2 && m2_bit_swt) ? ch_sel : 2'b00; // [R18]
	wire [1:0] crr    = (wr_m2 && m2_bit_crr) ? ch_sel : 2'b00;
	wire [1:0] rld    = (wr_m2 && m2_bit_rld) ? ch_sel : 2'b00;
	wire [7:0] m2_rd  = mode2[idx] & dma_pkg::MODE_SECOND_KEEP;
	wire [7:0] st_rd  = {idx, rld_dis, 4'h0, uf};
	wire [7:0] win_rd = hi ? work[idx][kk][15:8] : rdlo[idx][kk]; // [R13]
	wire [7:0] rd_mux =
		(i_sfr_addr == dma_pkg::A_INDEX_STATUS) ? st_rd :
		(i_sfr_addr == dma_pkg::A_MODE_FIRST)   ? mode1[idx] :
		(i_sfr_addr == dma_pkg::A_MODE_SECOND)  ? m2_rd :
		in_win ? win_rd : 8'h00;

	// ----------------------------------------
	// requests
	// ----------------------------------------
	wire [1:0] cond;
	assign cond[0] = req_cond(mode2[0][3:0], i_hw_req_ch0, // [R16]
		mode2[0][dma_pkg::ENDPOINT_HOSTPORT_ASSIST_ENABLE],
		i_outbuf_empty[0], i_inbuf_data[0]);
	assign cond[1] = req_cond(mode2[1][3:0], i_hw_req_ch1, // [R17]
		mode2[1][dma_pkg::ENDPOINT_HOSTPORT_ASSIST_ENABLE],
		i_outbuf_empty[1], i_inbuf_data[1]);
	wire [1:0] rise = cond & ~prev;
	wire [1:0] cen  = {mode1[1][dma_pkg::CHANNEL_ENABLE_BIT],
		mode1[0][dma_pkg::CHANNEL_ENABLE_BIT]};
	wire [1:0] can  = pend & cen;
	wire       halt = i_wait_state || i_stop_state || i_bus_hold; // [R4]
	wire       pick = !can[0]; // [R1]
	// a start also needs buffer room so a stalled write never drops a read byte
	wire       start = state == dma_pkg::IDLE && !halt && can != 2'b00
		&& buf_bus.push_ready;
	wire [1:0] take = start ? one_hot(pick) : 2'b00;

	// ----------------------------------------
	// byte completion
	// ----------------------------------------
	wire [7:0]  m1c   = mode1[ch];
	wire        done  = state == dma_pkg::WRITE && !i_mem_wait;
	wire        ufev  = done && work[ch][2] == 16'h0000; // [R24]
	wire [1:0]  uf_ch = ufev ? one_hot(ch) : 2'b00;
	wire [15:0] src_st = step(work[ch][0], m1c[dma_pkg::SRC_STEP_ENABLE],
		m1c[dma_pkg::SRC_STEP_DIRECTION]); // [R6]
	wire [15:0] dst_st = step(work[ch][1], m1c[dma_pkg::DST_STEP_ENABLE],
		m1c[dma_pkg::DST_STEP_DIRECTION]); // [R6]
	wire [15:0] cnt_dn = 16'(work[ch][2] - 16'h0001); // [R7]
	// a halt cuts a burst short; the rest needs a new request, since the
	// pending bit was spent when the burst began
	wire        burst_go = done && m1c[dma_pkg::BURST_MODE_SELECT] && !ufev
		&& !halt && buf_bus.push_ready; // [R23]

	assign buf_bus.push_valid = state == dma_pkg::READ; // [R2]
	assign buf_bus.push_data  = i_mem_rdata;
	assign buf_bus.pop_ready  = done;
	assign o_mem_wdata        = buf_bus.pop_data;

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	always_comb begin
		next_state = state;
		next_re    = 1'b0;
		next_we    = 1'b0;
		next_addr  = o_mem_addr;
		next_ch    = ch;
		unique case (state)
			dma_pkg::IDLE: begin
				if (start) begin
					next_state = dma_pkg::READ;
					next_re    = 1'b1;
					next_ch    = pick;
					next_addr  = work[pick][0];
				end
			end
			dma_pkg::READ: begin
				next_state = dma_pkg::WRITE; // [R2]
				next_we    = 1'b1;
				next_addr  = work[ch][1];
			end
			dma_pkg::WRITE: begin
				if (i_mem_wait) begin
					next_we = 1'b1;
				end else if (burst_go) begin
					next_state = dma_pkg::READ; // [R5]
					next_re    = 1'b1;
					next_addr  = src_st;
				end else begin
					// idle costs one free cpu cycle before any new start
					next_state = dma_pkg::IDLE; // [R3]
				end
			end
		endcase
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state       <= dma_pkg::IDLE;
			ch          <= 1'b0;
			o_mem_re    <= 1'b0;
			o_mem_we    <= 1'b0;
			o_mem_addr  <= dma_pkg::RESET_WORD;
			o_cpu_stall <= 1'b0;
			o_chan_irq  <= 2'b00;
		end else begin
			state       <= next_state;
			ch          <= next_ch;
			o_mem_re    <= next_re;
			o_mem_we    <= next_we;
			o_mem_addr  <= next_addr;
			o_cpu_stall <= next_state != dma_pkg::IDLE; // [R2]
			o_chan_irq  <= uf_ch; // [R7]
		end
	end

	// ----------------------------------------
	// request latches
	// ----------------------------------------
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			prev <= 2'b00;
			pend <= 2'b00;
		end else begin
			// edge capture: a level held high asks only once
			prev <= cond; // [R19]
			// a new event beats the clear so it is never lost
			pend <= (pend & ~(crr | take)) | rise | swt; // [R20] [R21]
		end
	end

	// ----------------------------------------
	// control and status
	// ----------------------------------------
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			idx     <= 1'b0;
			rld_dis <= 1'b0;
			uf      <= 2'b00;
			mode1   <= '{default: dma_pkg::RESET_BYTE};
			mode2   <= '{default: dma_pkg::RESET_BYTE};
		end else begin
			if (wr_idx) begin
				idx     <= i_sfr_wdata[dma_pkg::CHANNEL_SELECT_INDEX]; // [R14]
				rld_dis <= i_sfr_wdata[dma_pkg::GLOBAL_ADDR_RELOAD_DISABLE];
			end
			// writing zero clears a flag; a same-cycle underflow still sets it
			uf <= (wr_idx ? (uf & i_sfr_wdata[1:0]) : uf) | uf_ch; // [R7]
			if (wr_m1) begin
				mode1[idx] <= i_sfr_wdata;
			end
			if (wr_m2) begin
				mode2[idx] <= i_sfr_wdata & dma_pkg::MODE_SECOND_KEEP;
			end
			// placed last so the automatic disable beats a same-cycle mode write
			if (ufev && m1c[dma_pkg::STOP_AFTER_UNDERFLOW_OPTION]) begin
				mode1[ch][dma_pkg::CHANNEL_ENABLE_BIT] <= 1'b0; // [R9]
			end
		end
	end

	// ----------------------------------------
	// address and count registers
	// ----------------------------------------
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			work  <= '{default: '{default: dma_pkg::RESET_WORD}};
			latch <= '{default: '{default: dma_pkg::RESET_WORD}};
			wlo   <= '{default: '{default: dma_pkg::RESET_BYTE}};
		end else begin
			if (done) begin
				work[ch][0] <= (ufev && !rld_dis) ? latch[ch][0] : src_st; // [R8]
				work[ch][1] <= (ufev && !rld_dis) ? latch[ch][1] : dst_st; // [R8]
				work[ch][2] <= ufev ? latch[ch][2] : cnt_dn; // [R7]
			end
			// the reload bit follows the byte update so it wins; a high-byte
			// write without deferred write comes last and wins over both
			for (int c = 0; c < 2; c++) begin
				if (rld[c]) begin
					work[c] <= latch[c]; // [R10]
				end
			end
			if (wr_lo) begin
				wlo[idx][kk] <= i_sfr_wdata; // [R11]
			end
			if (wr_hi) begin
				latch[idx][kk] <= whole; // [R11]
				if (!mode1[idx][dma_pkg::DEFERRED_WRITE_CONTROL]) begin
					work[idx][kk] <= whole; // [R12]
				end
			end
		end
	end

	// ----------------------------------------
	// read path
	// ----------------------------------------
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			rdlo        <= '{default: '{default: dma_pkg::RESET_BYTE}};
			o_sfr_rdata <= dma_pkg::RESET_BYTE;
		end else begin
			// freezing the low byte keeps a running channel from tearing the word
			if (rd_hi) begin
				rdlo[idx][kk] <= work[idx][kk][7:0]; // [R13]
			end
			// only a read strobe moves the data, so the last byte stands meanwhile
			if (i_sfr_re) begin
				o_sfr_rdata <= rd_mux;
			end
		end
	end
endmodule

// file: core/dma_pkg.sv
// Purpose: shared constants for the two-channel byte mover
// Assumes: 8-bit register window, 16-bit memory map
// Notes:   hardware source codes 1..15 index the per-channel request vectors
package dma_pkg;
	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [7:0] A_INDEX_STATUS = 8'h3f;
	localparam logic [7:0] A_MODE_FIRST   = 8'h40;
	localparam logic [7:0] A_MODE_SECOND  = 8'h41;
	localparam logic [7:0] A_SOURCE_LOW   = 8'h42;
	localparam logic [7:0] A_SOURCE_HIGH  = 8'h43;
	localparam logic [7:0] A_DEST_LOW     = 8'h44;
	localparam logic [7:0] A_DEST_HIGH    = 8'h45;
	localparam logic [7:0] A_COUNT_LOW    = 8'h46;
	localparam logic [7:0] A_COUNT_HIGH   = 8'h47;
	localparam logic [7:0] RESET_BYTE     = 8'h00;
	localparam logic [15:0] RESET_WORD    = 16'h0000;
	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int COUNT_UNDERFLOW_FLAG0 = 0;
	localparam int GLOBAL_ADDR_RELOAD_DISABLE = 6;
	localparam int CHANNEL_SELECT_INDEX  = 7;
	localparam int SRC_STEP_DIRECTION    = 0;
	localparam int SRC_STEP_ENABLE       = 1;
	localparam int DST_STEP_DIRECTION    = 2;
	localparam int DST_STEP_ENABLE       = 3;
	localparam int DEFERRED_WRITE_CONTROL = 4;
	localparam int BURST_MODE_SELECT     = 5;
	localparam int STOP_AFTER_UNDERFLOW_OPTION = 6;
	localparam int CHANNEL_ENABLE_BIT    = 7;
	localparam int SOFTWARE_REQUEST_BIT  = 4;
	localparam int REQUEST_LATCH_CLEAR   = 5;
	localparam int FORCE_RELOAD_BIT      = 6;
	localparam int ENDPOINT_HOSTPORT_ASSIST_ENABLE = 7;
	localparam logic [7:0] MODE_SECOND_KEEP = 8'h8f;
	// ----------------------------------------
	// endpoint source codes and timing
	// ----------------------------------------
	localparam logic [3:0] HW_REQUEST_NONE = 4'h0;
	localparam logic [3:0] EP_RX_FIRST     = 4'h4;
	localparam logic [3:0] EP_RX_LAST      = 4'h6;
	localparam logic [3:0] EP_TX_FIRST     = 4'h7;
	localparam logic [3:0] EP_TX_LAST      = 4'h9;
	localparam logic [3:0] EP_NOT_EMPTY    = 4'ha;
	localparam int CYCLES_PER_BYTE = 2;
	localparam int CPU_GAP_CYCLES  = 1;
	typedef enum logic [1:0] {IDLE, READ, WRITE} mover_state_t;
endpackage

// file: core/hold_buffer.sv
// Purpose: two-entry holding buffer between source read and destination write
// Assumes: single clock, asynchronous active-high reset
// Notes:   head entry is a flop so the write data leaves straight from a register
`timescale 1ns/100ps
module hold_buffer (
	// clock and reset
	input  wire logic i_clk,
	input  wire logic i_rst,
	// buffer ports
	byte_buf_if.store bus
);
	logic [7:0] head;
	logic [7:0] tail;
	logic [1:0] fill;
	wire push = bus.push_valid && bus.push_ready;
	wire pop  = bus.pop_valid && bus.pop_ready;

	assign bus.push_ready = (fill != 2'd2);
	assign bus.pop_valid  = (fill != 2'd0);
	assign bus.pop_data   = head;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			fill <= 2'd0;
		end else begin
			fill <= 2'(fill + {1'b0, push} - {1'b0, pop});
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			head <= dma_pkg::RESET_BYTE;
			tail <= dma_pkg::RESET_BYTE;
		end else begin
			if (pop) begin
				head <= (fill == 2'd2) ? tail : bus.push_data;
			end else if (push && fill == 2'd0) begin
				head <= bus.push_data;
			end
			if (push && (fill - {1'b0, pop}) == 2'd1) begin
				tail <= bus.push_data;
			end
		end
	end
endmodule

// file: verif/byte_dma_sva.sv
// Purpose: port-level checks of the byte mover
// Assumes: one clock, async active-high reset
// Notes:   bound to every byte_dma instance
`timescale 1ns/100ps
module byte_dma_sva (
	// clock and reset
	input wire logic        i_clk,
	input wire logic        i_rst,
	// register window
	input wire logic [7:0]  i_sfr_addr,
	input wire logic        i_sfr_re,
	input wire logic [7:0]  o_sfr_rdata,
	// memory and cpu
	input wire logic [15:0] o_mem_addr,
	input wire logic        o_mem_re,
	input wire logic        o_mem_we,
	input wire logic [7:0]  o_mem_wdata,
	input wire logic        i_mem_wait,
	input wire logic        o_cpu_stall,
	input wire logic        i_wait_state,
	input wire logic        i_stop_state,
	input wire logic        i_bus_hold,
	input wire logic [1:0]  o_chan_irq
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_rst);
	wire halt = i_wait_state | i_stop_state | i_bus_hold;
	wire unmapped = (i_sfr_addr < 8'h3f) || (i_sfr_addr > 8'h47);
	// ----------------------------------------
	// transfer timing
	// ----------------------------------------
	AST_READ_THEN_WRITE: assert property (o_mem_re |=> o_mem_we && !o_mem_re)
		else $error("read cycle not followed by write");
	AST_WRITE_ENDS: assert property (o_mem_we && !i_mem_wait |=> !o_mem_we)
		else $error("write cycle overstays");
	AST_STALL_SPAN: assert property ((o_mem_re || o_mem_we) == o_cpu_stall)
		else $error("stall does not match transfer cycles");
	AST_WAIT_HOLD: assert property (o_mem_we && i_mem_wait
		|=> o_mem_we && $stable(o_mem_addr) && $stable(o_mem_wdata))
		else $error("write changed while waited");
	AST_HALT_BLOCKS: assert property (o_mem_re |-> !$past(halt))
		else $error("byte read started in halt state");
	// ----------------------------------------
	// underflow and registers
	// ----------------------------------------
	AST_IRQ_PULSE: assert property (|o_chan_irq
		|=> (o_chan_irq & $past(o_chan_irq)) == 2'b00)
		else $error("interrupt longer than one cycle");
	AST_IRQ_CAUSE: assert property (|o_chan_irq
		|-> $past(o_mem_we) && !$past(i_mem_wait))
		else $error("interrupt without completed write");
	AST_RDATA_HOLD: assert property (!$past(i_sfr_re) |-> $stable(o_sfr_rdata))
		else $error("read data moved without a read");
	AST_UNMAPPED_ZERO: assert property (i_sfr_re && unmapped
		|=> o_sfr_rdata == 8'h00)
		else $error("unmapped read not zero");
endmodule
bind byte_dma byte_dma_sva u_byte_dma_sva (.i_clk(i_clk), .i_rst(i_rst),
	.i_sfr_addr(i_sfr_addr), .i_sfr_re(i_sfr_re), .o_sfr_rdata(o_sfr_rdata),
	.o_mem_addr(o_mem_addr), .o_mem_re(o_mem_re), .o_mem_we(o_mem_we),
	.o_mem_wdata(o_mem_wdata), .i_mem_wait(i_mem_wait), .o_cpu_stall(o_cpu_stall),
	.i_wait_state(i_wait_state), .i_stop_state(i_stop_state), .i_bus_hold(i_bus_hold),
	.o_chan_irq(o_chan_irq));

// file: verif/mem_model.sv
// Purpose: memory seen by the byte mover
// Assumes: read data in the read cycle, write taken when not waited
// Notes:   byte at an address is its low byte xor 5a
`timescale 1ns/100ps
module mem_model (
	// clock and bus
	input  wire logic        i_clk,
	input  wire logic [15:0] i_addr,
	input  wire logic        i_re,
	input  wire logic        i_we,
	// pacing
	input  wire logic        i_slow,
	// answers
	output logic      [7:0]  o_rdata,
	output logic             o_wait
);
	logic [7:0] last = 8'h00;
	logic       waited = 1'b0;
	// outside a read the data lines show garbage, never the last byte
	assign o_rdata = i_re ? (i_addr[7:0] ^ 8'h5a) : ~last;
	// slow mode holds off each write for one cycle
	assign o_wait = i_slow && i_we && !waited;
	always @(posedge i_clk) begin
		if (i_re)
			last <= i_addr[7:0] ^ 8'h5a;
		waited <= i_we && o_wait;
	end
endmodule

// file: verif/tb_top.sv
// Purpose: register-level regression of the byte mover
// Assumes: inputs driven on falling edge
// Notes:   expected bytes follow the memory model's xor pattern
`timescale 1ns/100ps
module tb_top;
	logic clk, rst, sre, swe, slow;
	logic [7:0] sa, swd, rdat, wd, h, l;
	logic [15:0] ma, rq0, rq1;
	logic mre, mwe, mwt, stall;
	logic [7:0] mrd;
	logic [2:0] hlt;
	logic [1:0] irq, ob, ib;
	int err_count, compares, idle;
	byte_dma u_byte_dma (.i_clk(clk), .i_rst(rst), .i_sfr_addr(sa),
		.i_sfr_wdata(swd), .i_sfr_we(swe), .i_sfr_re(sre), .o_sfr_rdata(rdat),
		.o_mem_addr(ma), .o_mem_re(mre), .o_mem_we(mwe), .o_mem_wdata(wd),
		.i_mem_rdata(mrd), .i_mem_wait(mwt), .o_cpu_stall(stall),
		.i_wait_state(hlt[0]), .i_stop_state(hlt[1]), .i_bus_hold(hlt[2]),
		.i_hw_req_ch0(rq0), .i_hw_req_ch1(rq1), .i_outbuf_empty(ob),
		.i_inbuf_data(ib), .o_chan_irq(irq));
	mem_model u_mem_model (.i_clk(clk), .i_addr(ma), .i_re(mre), .i_we(mwe),
		.i_slow(slow), .o_rdata(mrd), .o_wait(mwt));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// ----------------------------------------
	// access tasks
	// ----------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		sa = a;
		swd = d;
		swe = 1'b1;
		@(negedge clk);
		swe = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		sa = a;
		sre = 1'b1;
		@(negedge clk);
		sre = 1'b0;
		d = rdat;
	endtask
	task automatic c8(input logic [7:0] a, input logic [7:0] e);
		rd(a, l);
		chk({8'h00, l}, {8'h00, e});
	endtask
	task automatic w16(input logic [7:0] a, input logic [15:0] v);
		wr(a, v[7:0]);
		wr(a + 8'h01, v[15:8]);
	endtask
	// high byte first, low byte is the value captured then
	task automatic c16(input logic [7:0] a, input logic [15:0] e);
		rd(a + 8'h01, h);
		rd(a, l);
		chk({h, l}, e);
	endtask
	task automatic sel(input logic c, input logic g);
		wr(8'h3f, {c, g, 6'h00});
	endtask
	task automatic setup(input logic [15:0] s, d, n, input logic [7:0] m);
		wr(8'h40, m);
		w16(8'h42, s);
		w16(8'h44, d);
		w16(8'h46, n);
	endtask
	task automatic trig();
		wr(8'h41, 8'h10);
	endtask
	task automatic no_move(input int n);
		repeat (n) @(negedge clk) chk({15'h0000, stall}, 16'h0000);
	endtask
	// one byte written to d, read from s, with lo..hi stall-free cycles before it
	task automatic xfer(input logic [15:0] s, d, input int lo, hi);
		idle = 0;
		for (int n = 0; n < 80; n++) begin
			@(negedge clk);
			if (mwe === 1'b1 && mwt === 1'b0) begin
				chk(ma, d);
				chk({8'h00, wd}, {8'h00, s[7:0] ^ 8'h5a});
				chk({15'h0000, idle >= lo && idle <= hi}, 16'h0001);
				return;
			end
			if (stall === 1'b0)
				idle++;
		end
		err_count++;
		$display("[ERR] %0t no write seen", $time);
	endtask
	task automatic final_report();
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		$display("[ERR] %0t watchdog expired", $time);
		final_report();
	end
	// ----------------------------------------
	// test sequence
	// ----------------------------------------
	initial begin
		{rst, sre, swe, slow, sa, swd, rq0, rq1, hlt, ob, ib} = '0;
		err_count = 0;
		compares = 0;
		rst = 1'b1;
		repeat (3) @(posedge clk);
		@(negedge clk) rst = 1'b0;
		for (int c = 0; c < 2; c++) begin
			sel(c[0], 1'b0);
			c8(8'h3f, {c[0], 7'h00});
			for (int a = 8'h40; a < 8'h48; a++) c8(a[7:0], 8'h00);
		end
		c8(8'h30, 8'h00);
		$display("test reset values done");
		sel(1'b0, 1'b0);
		w16(8'h42, 16'h1234);
		c16(8'h42, 16'h1234);
		wr(8'h40, 8'h10);
		w16(8'h42, 16'h5678);
		c16(8'h42, 16'h1234);
		wr(8'h41, 8'h40);
		c16(8'h42, 16'h5678);
		$display("test latches done");
		setup(16'h0010, 16'h0020, 16'h0001, 8'h8a);
		trig();
		xfer(16'h0010, 16'h0020, 0, 80);
		c16(8'h42, 16'h0011);
		c16(8'h44, 16'h0021);
		c16(8'h46, 16'h0000);
		trig();
		xfer(16'h0011, 16'h0021, 0, 80);
		@(negedge clk) chk({14'h0000, irq}, 16'h0001);
		c8(8'h3f, 8'h01);
		c16(8'h42, 16'h0010);
		c16(8'h46, 16'h0001);
		$display("test single byte done");
		sel(1'b0, 1'b1);
		setup(16'h0000, 16'h0100, 16'h0000, 8'hcf);
		slow = 1'b1;
		trig();
		xfer(16'h0000, 16'h0100, 0, 80);
		slow = 1'b0;
		c16(8'h42, 16'hffff);
		c16(8'h44, 16'h00ff);
		c16(8'h46, 16'h0000);
		c8(8'h40, 8'h4f);
		c8(8'h3f, 8'h41);
		$display("test decrement done");
		sel(1'b0, 1'b0);
		setup(16'h0200, 16'h0300, 16'h0002, 8'haa);
		trig();
		xfer(16'h0200, 16'h0300, 0, 80);
		xfer(16'h0201, 16'h0301, 0, 0);
		xfer(16'h0202, 16'h0302, 0, 0);
		no_move(4);
		$display("test burst done");
		setup(16'h0800, 16'h0900, 16'h00ff, 8'h8a);
		for (int k = 0; k < 3; k++) begin
			hlt = 3'b001 << k;
			trig();
			no_move(6);
			hlt = 3'b000;
			// the held request starts in the very cycle the halt lifts
			xfer(16'h0800 + k[15:0], 16'h0900 + k[15:0], 0, 0);
		end
		hlt = 3'b001;
		trig();
		wr(8'h41, 8'h20);
		hlt = 3'b000;
		no_move(6);
		hlt = 3'b001;
		trig();
		trig();
		hlt = 3'b000;
		xfer(16'h0803, 16'h0903, 0, 0);
		no_move(6);
		$display("test halt and latch done");
		setup(16'h0400, 16'h0500, 16'h0005, 8'h8a);
		rq0 = 16'hfffe;
		no_move(3);
		rq0 = 16'h0000;
		wr(8'h41, 8'h01);
		sel(1'b1, 1'b0);
		setup(16'h0600, 16'h0700, 16'h0005, 8'h8a);
		wr(8'h41, 8'h01);
		no_move(3);
		@(negedge clk);
		rq0 = 16'h0002;
		rq1 = 16'h0002;
		xfer(16'h0400, 16'h0500, 0, 80);
		xfer(16'h0600, 16'h0700, 1, 80);
		rq0 = 16'h0000;
		rq1 = 16'h0000;
		$display("test priority done");
		wr(8'h41, 8'h84);
		rq1 = 16'h0010;
		no_move(4);
		ob = 2'b10;
		xfer(16'h0601, 16'h0701, 0, 80);
		wr(8'h41, 8'h87);
		no_move(4);
		ib = 2'b10;
		xfer(16'h0602, 16'h0702, 0, 80);
		{ob, ib, rq1} = '0;
		$display("test assist done");
		final_report();
	end
endmodule
